//--- core/adchri_pkg.sv
package adchri_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int DI_W = 16;
  localparam int OFS_W = 4;
  localparam int CHAN_W = 6;
  localparam int CODE_W = 4;
  localparam int GAIN_W = 3;
  localparam int IDX_W = 4;

  localparam logic [OFS_W-1:0] OFS_SAMPLE_LO = 4'h4;
  localparam logic [OFS_W-1:0] OFS_SAMPLE_HI = 4'h5;
  localparam logic [OFS_W-1:0] OFS_INPUT_LO = 4'h6;
  localparam logic [OFS_W-1:0] OFS_INPUT_HI = 4'h7;
  localparam logic [OFS_W-1:0] OFS_RANGE = 4'h9;
  localparam logic [OFS_W-1:0] OFS_CHANNEL = 4'hA;
  localparam logic [OFS_W-1:0] OFS_KICK = 4'hC;
  localparam logic [OFS_W-1:0] OFS_OUT_LO = 4'hD;
  localparam logic [OFS_W-1:0] OFS_OUT_HI = 4'hE;
  localparam logic [OFS_W-1:0] OFS_SPARE = 4'hF;

  localparam int CH_BANK_LO_BIT = 4;
  localparam int CH_BANK_HI_BIT = 5;
  localparam int CH_IDX_MSB = 3;
  localparam int RANGE_UNI_BIT = 2;
  localparam int RANGE_HALF_BIT = 3;
  localparam int HIGH_NIBBLE_W = SAMPLE_W - DATA_W;

  localparam logic FLAG_RESET = 1'b1;
  localparam logic [CHAN_W-1:0] CHANNEL_RESET = 6'h00;
  localparam logic [CODE_W-1:0] RANGE_RESET = 4'h0;
  localparam logic [2:0] HIGH_PAD = 3'h0;
  localparam logic [GAIN_W-1:0] SE_MAX_GAIN = 3'h4;
  localparam logic [CODE_W-1:0] LOW_HALF_CODE = 4'h8;

  typedef enum logic [2:0] {
    VAR_LOW_GAIN = 3'b001,
    VAR_HIGH_GAIN = 3'b010,
    VAR_SE_ONLY = 3'b100
  } adchri_variant_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } adchri_conv_t;

  typedef struct packed {
    logic aen;
    logic rdN;
    logic wrN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DI_W-1:0] di;
  } adchri_pins_t;

  typedef struct packed {
    logic bankLow;
    logic bankHigh;
    logic differential;
    logic [IDX_W-1:0] index;
  } adchri_mux_t;

  typedef struct packed {
    logic [GAIN_W-1:0] gainStep;
    logic halfGain;
    logic unipolar;
    logic valid;
  } adchri_range_t;
endpackage

//--- core/adchri_core.sv
`timescale 1ns/1ps
// Behaviour
// - Decode sixteen bytes at base, last unused
// - Offsets four to seven split read/write
// - Result low byte offset 4, high nibble 5
// - High byte: zeros above, flag bit 4
// - Flag one until result held, then zero
// - Reading low byte sets flag back
// - Host writes never alter stored result
// - Channel register at 10, write only
// - Mux holds channel until conversion passes
// - Index in bits 3..0, top bits ignored
// - Bit 4 alone enables low bank
// - Bit 5 alone enables high bank
// - Both bank bits select differential pairs
// - Range register at 9, code bits 3..0
// - Gain variants: code bit 2 unipolar
// - Single-ended variant: gain only, bit 3 unused
// - High gain: decades, half bipolar, 11 invalid
// - Low gain: binary steps, 1000 half bipolar
// - Single-ended variant: codes 0..4 gains 1..16
module adchri_core
  import adchri_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 10'h220,
  parameter adchri_variant_t VARIANT = VAR_HIGH_GAIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire adchri_pins_t busPins,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic convStart,
  input wire logic convDone,
  input wire logic [SAMPLE_W-1:0] convData,
  output adchri_mux_t muxSel,
  output adchri_range_t rangeSel,
  output logic [SAMPLE_W-1:0] dacOne,
  output logic [SAMPLE_W-1:0] dacTwo,
  output logic [DI_W-1:0] digOut
);
  localparam int PIN_W = $bits(adchri_pins_t);

  if (BASE_ADDR[OFS_W-1:0] != '0) begin : g_bad_base
    $error("Base address must be aligned to sixteen bytes");
  end

  logic [PIN_W-1:0] syncA_reg;
  logic [PIN_W-1:0] syncB_reg;
  logic [PIN_W-1:0] syncC_reg;
  logic [PIN_W-1:0] pinFilt_reg;
  adchri_pins_t pins;
  logic rdPrev_reg;
  logic wrPrev_reg;
  logic hit;
  logic [OFS_W-1:0] ofs;
  logic rdStart;
  logic wrEnd;
  logic readable;
  logic [DATA_W-1:0] readData;
  logic [DATA_W-1:0] dataOut_reg;
  logic dataOe_reg;
  logic flag_reg;
  logic [SAMPLE_W-1:0] result_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [CODE_W-1:0] range_reg;
  adchri_mux_t muxSel_reg;
  adchri_range_t rangeSel_reg;
  adchri_conv_t convState_reg;
  logic convStart_reg;
  logic kickWrite;
  logic [DATA_W-1:0] dacOneLo_reg;
  logic [DATA_W-1:0] dacTwoLo_reg;
  logic [SAMPLE_W-1:0] dacOne_reg;
  logic [SAMPLE_W-1:0] dacTwo_reg;
  logic [DI_W-1:0] digOut_reg;

  function automatic adchri_mux_t muxDecode(input logic [CHAN_W-1:0] chan);
    adchri_mux_t m;
    m = '0;
    m.index = chan[CH_IDX_MSB:0];
    if (VARIANT != VAR_SE_ONLY) begin
      m.bankLow = chan[CH_BANK_LO_BIT] & ~chan[CH_BANK_HI_BIT];
      m.bankHigh = chan[CH_BANK_HI_BIT] & ~chan[CH_BANK_LO_BIT];
      m.differential = chan[CH_BANK_HI_BIT] & chan[CH_BANK_LO_BIT];
      if (m.differential) begin
        m.index[CH_IDX_MSB] = 1'b0;
      end
    end
    return m;
  endfunction

  function automatic adchri_range_t rangeDecode(input logic [CODE_W-1:0] code);
    adchri_range_t r;
    r = '0;
    unique case (VARIANT)
      VAR_HIGH_GAIN: begin
        r.gainStep = {1'b0, code[1:0]};
        r.unipolar = code[RANGE_UNI_BIT];
        r.halfGain = code[RANGE_HALF_BIT] & ~code[RANGE_UNI_BIT];
        r.valid = ~(code[RANGE_HALF_BIT] & code[RANGE_UNI_BIT]);
      end
      VAR_LOW_GAIN: begin
        r.gainStep = {1'b0, code[1:0]};
        r.unipolar = code[RANGE_UNI_BIT];
        r.halfGain = (code == LOW_HALF_CODE);
        r.valid = ~code[RANGE_HALF_BIT] | r.halfGain;
        if (r.halfGain) begin
          r.gainStep = '0;
        end
      end
      VAR_SE_ONLY: begin
        // Full-scale choice is a board jumper, so no polarity output here
        r.gainStep = code[GAIN_W-1:0];
        r.valid = (code[GAIN_W-1:0] <= SE_MAX_GAIN);
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // Three-stage capture; only the agreed value of stages two and three is used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= '1;
      syncB_reg <= '1;
      syncC_reg <= '1;
      pinFilt_reg <= '1;
    end else begin
      syncA_reg <= busPins;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      pinFilt_reg <= (syncB_reg & syncC_reg) | (pinFilt_reg & (syncB_reg ^ syncC_reg));
    end
  end

  assign pins = adchri_pins_t'(pinFilt_reg);
  assign ofs = pins.addr[OFS_W-1:0];
  assign hit = ~pins.aen && (pins.addr[ADDR_W-1:OFS_W] == BASE_ADDR[ADDR_W-1:OFS_W]);
  assign rdStart = hit && !pins.rdN && rdPrev_reg;
  // Writes act on the trailing edge, where the host data is surely settled
  assign wrEnd = hit && pins.wrN && !wrPrev_reg;
  assign kickWrite = wrEnd && (ofs == OFS_KICK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
    end else begin
      rdPrev_reg <= pins.rdN;
      wrPrev_reg <= pins.wrN;
    end
  end

  // Only the data bytes drive the bus; other offsets, spare included, stay off
  always_comb begin
    readable = 1'b1;
    readData = '0;
    unique case (ofs)
      OFS_SAMPLE_LO: readData = result_reg[DATA_W-1:0];
      OFS_SAMPLE_HI: readData = {HIGH_PAD, flag_reg, result_reg[SAMPLE_W-1:DATA_W]};
      OFS_INPUT_LO: readData = pins.di[DATA_W-1:0];
      OFS_INPUT_HI: readData = pins.di[DI_W-1:DATA_W];
      default: readable = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_reg <= '0;
      dataOe_reg <= 1'b0;
    end else begin
      if (rdStart) begin
        dataOut_reg <= readData;
      end
      dataOe_reg <= hit && !pins.rdN && readable;
    end
  end

  // A finished conversion outranks a low-byte read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= FLAG_RESET;
    end else if (convDone) begin
      flag_reg <= 1'b0;
    end else if (rdStart && ofs == OFS_SAMPLE_LO) begin
      flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= '0;
    end else if (convDone) begin
      result_reg <= convData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg <= CHANNEL_RESET;
      range_reg <= RANGE_RESET;
    end else if (wrEnd) begin
      if (ofs == OFS_CHANNEL) begin
        chan_reg <= pins.data[CHAN_W-1:0];
      end
      if (ofs == OFS_RANGE) begin
        range_reg <= pins.data[CODE_W-1:0];
      end
    end
  end

  // Settings are copied out only between conversions, so a running one is undisturbed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      muxSel_reg <= '0;
      rangeSel_reg <= '0;
    end else if (convState_reg == CONV_IDLE) begin
      muxSel_reg <= muxDecode(chan_reg);
      rangeSel_reg <= rangeDecode(range_reg);
    end
  end

  // A kick while busy is dropped; the converter owns the channel until done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convState_reg <= CONV_IDLE;
      convStart_reg <= 1'b0;
    end else begin
      convStart_reg <= 1'b0;
      unique case (convState_reg)
        CONV_IDLE: begin
          if (kickWrite) begin
            convStart_reg <= 1'b1;
            convState_reg <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (convDone) begin
            convState_reg <= CONV_IDLE;
          end
        end
        default: begin
          convState_reg <= CONV_IDLE;
        end
      endcase
    end
  end

  // Output bytes of each analog channel move together on the high byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacOneLo_reg <= '0;
      dacTwoLo_reg <= '0;
      dacOne_reg <= '0;
      dacTwo_reg <= '0;
      digOut_reg <= '0;
    end else if (wrEnd) begin
      unique case (ofs)
        OFS_SAMPLE_LO: dacOneLo_reg <= pins.data;
        OFS_SAMPLE_HI: dacOne_reg <= {pins.data[HIGH_NIBBLE_W-1:0], dacOneLo_reg};
        OFS_INPUT_LO: dacTwoLo_reg <= pins.data;
        OFS_INPUT_HI: dacTwo_reg <= {pins.data[HIGH_NIBBLE_W-1:0], dacTwoLo_reg};
        OFS_OUT_LO: digOut_reg[DATA_W-1:0] <= pins.data;
        OFS_OUT_HI: digOut_reg[DI_W-1:DATA_W] <= pins.data;
        default: begin
        end
      endcase
    end
  end

  assign dataOut = dataOut_reg;
  assign dataOe = dataOe_reg;
  assign convStart = convStart_reg;
  assign muxSel = muxSel_reg;
  assign rangeSel = rangeSel_reg;
  assign dacOne = dacOne_reg;
  assign dacTwo = dacTwo_reg;
  assign digOut = digOut_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence loRead;
    rdStart && ofs == OFS_SAMPLE_LO;
  endsequence

  sequence hiRead;
    rdStart && ofs == OFS_SAMPLE_HI;
  endsequence

  sequence kickIdle;
    kickWrite && convState_reg == CONV_IDLE;
  endsequence

  window_drive_a: assert property (dataOe_reg |-> $past(hit) && $past(ofs) != OFS_SPARE)
    else $error("Bus driven outside the decoded window");
  input_read_a: assert property (rdStart && ofs == OFS_INPUT_LO |=> dataOe_reg
    && dataOut_reg == $past(pins.di[DATA_W-1:0]))
    else $error("Input low byte not returned");
  result_low_a: assert property (loRead |=> dataOut_reg == $past(result_reg[DATA_W-1:0]))
    else $error("Result low byte wrong");
  result_high_a: assert property (hiRead |=> dataOut_reg[DATA_W-1:CH_BANK_LO_BIT+1] == '0
    && dataOut_reg[CH_BANK_LO_BIT] == $past(flag_reg)
    && dataOut_reg[HIGH_NIBBLE_W-1:0] == $past(result_reg[SAMPLE_W-1:DATA_W]))
    else $error("Result high byte layout wrong");
  flag_done_a: assert property (convDone |=> !flag_reg && result_reg == $past(convData))
    else $error("Finished result not held");
  // Only a finished conversion may pull the flag down again right after the read
  flag_consume_a: assert property (loRead ##0 !convDone |=> flag_reg
    ##1 (flag_reg || $past(convDone)))
    else $error("Low byte read did not mark result consumed");
  result_guard_a: assert property (!convDone |=> $stable(result_reg))
    else $error("Result changed without a conversion");
  mux_hold_a: assert property (convState_reg == CONV_BUSY |=> $stable(muxSel_reg)
    && $stable(rangeSel_reg))
    else $error("Settings changed during a conversion");
  kick_start_a: assert property (kickIdle |=> convStart_reg && convState_reg == CONV_BUSY
    ##1 !convStart_reg)
    else $error("Kick did not start exactly one conversion");
  bank_decode_a: assert property (convState_reg == CONV_IDLE && VARIANT != VAR_SE_ONLY
    && chan_reg[CH_BANK_HI_BIT:CH_BANK_LO_BIT] == 2'b11 |=> muxSel_reg.differential
    && !muxSel_reg.bankLow && !muxSel_reg.bankHigh)
    else $error("Differential selection not decoded");
  range_invalid_a: assert property (convState_reg == CONV_IDLE && VARIANT == VAR_HIGH_GAIN
    && range_reg[RANGE_HALF_BIT] && range_reg[RANGE_UNI_BIT] |=> !rangeSel_reg.valid)
    else $error("Undefined range code marked valid");
endmodule

//--- sim/adchri_conv_model.sv
`timescale 1ns/1ps
module adchri_conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convStart,
  input wire logic [15:0] delayCycles,
  input wire logic [11:0] sample,
  output logic convDone,
  output logic [11:0] convData
);
  logic busyReg;
  logic [15:0] cntReg;
  // Data lines toggle outside the done pulse so a late sample never looks valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyReg <= 1'b0;
      cntReg <= 16'h0000;
      convDone <= 1'b0;
      convData <= 12'hA5A;
    end else begin
      convDone <= 1'b0;
      if (convStart) begin
        busyReg <= 1'b1;
        cntReg <= delayCycles;
        convData <= ~convData;
      end else if (busyReg && cntReg <= 16'h0001) begin
        busyReg <= 1'b0;
        convDone <= 1'b1;
        convData <= sample;
      end else begin
        if (busyReg) begin
          cntReg <= cntReg - 16'h0001;
        end
        convData <= ~convData;
      end
    end
  end
endmodule

//--- sim/test_adchri_core.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_adchri_core;
  import adchri_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 10'h220;
  logic clk, rst_n, convStart, convDone, dataOe, startSeen;
  adchri_pins_t pins;
  logic [DATA_W-1:0] dataOut, lo, hi;
  logic [SAMPLE_W-1:0] convData, dacOne, dacTwo, smp;
  logic [15:0] digOut, dly;
  adchri_mux_t muxSel, startMux;
  adchri_range_t rangeSel, startRange;
  adchri_mux_t seMux;
  adchri_range_t seRange, lgRange;
  int error_cnt = 0;
  int tests_run = 0;
  int startCnt = 0;
  logic [3:0] noRd [8] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};

  adchri_core #(.BASE_ADDR(BASE), .VARIANT(VAR_HIGH_GAIN)) adchri_core_inst (.clk(clk),
    .rst_n(rst_n), .busPins(pins), .dataOut(dataOut), .dataOe(dataOe), .convStart(convStart),
    .convDone(convDone), .convData(convData), .muxSel(muxSel), .rangeSel(rangeSel),
    .dacOne(dacOne), .dacTwo(dacTwo), .digOut(digOut));
  adchri_conv_model adchri_conv_model_inst (.clk(clk), .rst_n(rst_n), .convStart(convStart),
    .delayCycles(dly), .sample(smp), .convDone(convDone), .convData(convData));
  // Other board variants share the bus and the converter, seen only through their decode
  if (1) begin : g_se
    adchri_core #(.BASE_ADDR(BASE), .VARIANT(VAR_SE_ONLY)) adchri_core_inst (.clk(clk),
      .rst_n(rst_n), .busPins(pins), .dataOut(), .dataOe(), .convStart(),
      .convDone(convDone), .convData(convData), .muxSel(seMux), .rangeSel(seRange),
      .dacOne(), .dacTwo(), .digOut());
  end
  if (1) begin : g_lg
    adchri_core #(.BASE_ADDR(BASE), .VARIANT(VAR_LOW_GAIN)) adchri_core_inst (.clk(clk),
      .rst_n(rst_n), .busPins(pins), .dataOut(), .dataOe(), .convStart(),
      .convDone(convDone), .convData(convData), .muxSel(), .rangeSel(lgRange),
      .dacOne(), .dacTwo(), .digOut());
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Settings are captured one cycle after the start pulse, when they must be frozen
  always @(posedge clk) begin
    startSeen <= convStart;
    if (startSeen === 1'b1) begin
      startMux <= muxSel;
      startRange <= rangeSel;
      startCnt <= startCnt + 1;
    end
  end

  function automatic adchri_mux_t expMux(input logic [7:0] ch);
    adchri_mux_t m;
    m.bankLow = ch[4] & ~ch[5];
    m.bankHigh = ch[5] & ~ch[4];
    m.differential = ch[5] & ch[4];
    m.index = m.differential ? {1'h0, ch[2:0]} : ch[3:0];
    return m;
  endfunction

  function automatic adchri_range_t expRange(input logic [3:0] c);
    adchri_range_t r;
    r.gainStep = {1'h0, c[1:0]};
    r.halfGain = c[3] & ~c[2];
    r.unipolar = c[2];
    r.valid = ~(c[3] & c[2]);
    return r;
  endfunction

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic hit, input logic [7:0] exp);
    logic seen;
    logic [7:0] val;
    seen = 1'b0;
    val = 8'h00;
    @(negedge clk);
    pins.aen = 1'b0;
    pins.addr = a;
    pins.rdN = 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (dataOe === 1'b1 && !seen) begin
        seen = 1'b1;
        val = dataOut;
      end
    end
    pins.rdN = 1'b1;
    repeat (10) @(negedge clk);
    pins.aen = 1'b1;
    `CHK(seen, hit)
    if (hit) `CHK(val, exp)
  endtask

  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    @(negedge clk);
    pins.aen = 1'b0;
    pins.addr = BASE | 10'(o);
    pins.data = d;
    pins.wrN = 1'b0;
    repeat (6) @(negedge clk);
    pins.wrN = 1'b1;
    repeat (10) @(negedge clk);
    pins.aen = 1'b1;
  endtask

  task automatic conv(input logic [7:0] ch, input logic [7:0] code, input logic rd);
    int prev;
    adchri_mux_t m;
    adchri_range_t r;
    m = expMux(ch);
    r = expRange(code[3:0]);
    smp = 12'($urandom);
    dly = 16'($urandom_range(1, 20));
    wr(OFS_CHANNEL, ch);
    wr(OFS_RANGE, code);
    prev = startCnt;
    wr(OFS_KICK, 8'($urandom));
    `CHK(startCnt, prev + 1)
    `CHK(startMux.index, m.index)
    `CHK(startMux.differential, m.differential)
    if (!m.differential) `CHK(startMux.bankLow, m.bankLow)
    if (!m.differential) `CHK(startMux.bankHigh, m.bankHigh)
    `CHK(startRange.valid, r.valid)
    if (r.valid) `CHK(startRange.gainStep, r.gainStep)
    if (r.valid) `CHK(startRange.unipolar, r.unipolar)
    if (r.valid) `CHK(startRange.halfGain, r.halfGain)
    repeat (int'(dly) + 8) @(negedge clk);
    if (rd) begin
      rdChk(BASE | 10'h5, 1'b1, {3'h0, 1'h0, smp[11:8]});
      rdChk(BASE | 10'h4, 1'b1, smp[7:0]);
      rdChk(BASE | 10'h5, 1'b1, {3'h0, 1'h1, smp[11:8]});
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim;
  end

  initial begin
    int mode;
    pins = '{aen: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
    rst_n = 1'b0;
    dly = 16'h0004;
    smp = 12'h000;
    void'($urandom(32'hF3D960A2));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    rdChk(BASE | 10'h5, 1'b1, 8'h10);
    rdChk(BASE | 10'h4, 1'b1, 8'h00);
    // Every range code once, with a random legal channel and junk in ignored bits
    for (int i = 0; i < 16; i++) begin
      mode = $urandom_range(1, 3);
      conv({2'($urandom), mode[1:0], 1'(mode == 2), 3'($urandom)}, {4'($urandom), 4'(i)}, 1'b1);
    end
    conv(8'h31, 8'h05, 1'b0);
    lo = 8'($urandom);
    hi = 8'($urandom);
    wr(OFS_SAMPLE_LO, lo);
    wr(OFS_SAMPLE_HI, hi);
    `CHK(dacOne, {hi[3:0], lo})
    rdChk(BASE | 10'h5, 1'b1, {3'h0, 1'h0, smp[11:8]});
    rdChk(BASE | 10'h4, 1'b1, smp[7:0]);
    wr(OFS_INPUT_LO, hi);
    wr(OFS_INPUT_HI, lo);
    `CHK(dacTwo, {lo[3:0], hi})
    pins.di = 16'($urandom);
    rdChk(BASE | 10'h6, 1'b1, pins.di[7:0]);
    rdChk(BASE | 10'h7, 1'b1, pins.di[15:8]);
    foreach (noRd[k]) rdChk(BASE | 10'(noRd[k]), 1'b0, 8'h00);
    rdChk(BASE + 10'h014, 1'b0, 8'h00);
    // A channel write during a long conversion must wait until that conversion ends
    wr(OFS_CHANNEL, 8'h13);
    dly = 16'h012C;
    wr(OFS_KICK, 8'h00);
    wr(OFS_CHANNEL, 8'h2C);
    `CHK(muxSel, expMux(8'h13))
    repeat (300) @(negedge clk);
    `CHK(muxSel, expMux(8'h2C))
    wr(OFS_OUT_LO, lo);
    wr(OFS_OUT_HI, hi);
    `CHK(digOut, {hi, lo})
    // Single-ended and low-gain variants: bank bits held at zero by the host
    for (int i = 0; i < 16; i++) begin
      lo = {2'($urandom), 2'b00, 4'($urandom)};
      wr(OFS_CHANNEL, lo);
      wr(OFS_RANGE, {4'($urandom), 4'(i)});
      `CHK(seMux, {3'h0, lo[3:0]})
      `CHK(seRange.gainStep, 3'(i))
      `CHK(seRange.valid, 1'(i % 8 <= 4))
      `CHK(seRange.unipolar, 1'b0)
      `CHK(lgRange.valid, 1'(i <= 8))
      if (i == 8) `CHK(lgRange.halfGain, 1'b1)
      if (i < 8) `CHK(lgRange.gainStep, 3'(i % 4))
      if (i < 8) `CHK(lgRange.unipolar, 1'(i / 4))
    end
    end_sim;
  end
endmodule
